// ==== clkbuf_cfg.svh ====
// Offsets, field positions, reset values and address constants of the clock buffer control
`ifndef CLKBUF_CFG_SVH
`define CLKBUF_CFG_SVH
// APB byte addresses
`define APB_CTRL0 8'h00
`define APB_CTRL1 8'h04
`define APB_STATUS 8'h08
// Index-addressed SMBus registers
`define SMB_REG_CTRL0 8'h00
`define SMB_REG_CTRL1 8'h01
// CTRL1 fields
`define CTRL1_OE_HI_LSB 0
`define CTRL1_OE_HI_MSB 3
`define CTRL1_RATE10 4
`define CTRL1_RATE11 5
// Reset values: all pairs enabled by software, pairs 10/11 geared
`define CTRL0_RST 8'hff
`define CTRL1_RST 8'h0f
// Slave address: upper bits fixed, low three bits from the select inputs
`define SMB_ADDR_BASE 4'hd
// Bit count of a byte plus its acknowledge slot
`define SMB_ACK_SLOT 4'h8
`define SMB_LAST_BIT 4'h7
`endif

// ==== clkbuf_ctrl.sv ====
// Clock buffer output-enable, strap and SMBus block-write control with APB access
`timescale 1ns/1ps
`default_nettype none
`include "clkbuf_cfg.svh"
module clkbuf_ctrl import clkbuf_pkg::*; (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic [9:0] OE_N,
  input wire logic OE_10_11_N,
  input wire logic PLL_BANDWIDTH_SELECT,
  input wire logic [2:0] BUS_ADDRESS_SELECT,
  input wire logic FREQUENCY_RANGE_SELECT,
  input wire logic POWER_GOOD_POWERDOWN,
  output logic [11:0] DIFF_CLOCK_OUT_EN,
  output logic PLL_PLL_BANDWIDTH_SELECT,
  output logic PLL_BYPASS,
  output logic FREQ_RANGE_HIGH,
  output logic POWER_DOWN,
  output logic [1:0] PAIR_INPUT_RATE
);
  // Bit 2 of the address select is the shared address/bypass pin
  function automatic logic [1:0] reg_sel(input logic [7:0] a);
    case (a)
      `APB_CTRL0: reg_sel = 2'h0;
      `APB_CTRL1: reg_sel = 2'h1;
      `APB_STATUS: reg_sel = 2'h2;
      default: reg_sel = 2'h3;
    endcase
  endfunction : reg_sel

  // Start detection, clocked by the data line
  logic start_tog_r, start_tog_nxt;
  // A fall of data while the clock is high marks a start or repeated start
  always_comb begin
    start_tog_nxt = SCL ? ~start_tog_r : start_tog_r;
  end
  always_ff @(negedge SDA_IN or negedge RST_N) begin
    if (!RST_N) start_tog_r <= 1'b0;
    else start_tog_r <= start_tog_nxt;
  end

  // Link domain, clocked by SCL
  link_state_e state_r, state_nxt;
  logic [3:0] bitcnt_r, bitcnt_nxt;
  logic [7:0] shift_r, shift_nxt, ptr_r, ptr_nxt, remain_r, remain_nxt;
  logic ack_r, ack_nxt, start_seen_r, start_seen_nxt, wr_tog_r, wr_tog_nxt;
  // Two slots, filled in turn: at this link rate the next byte arrives before the
  // toggle has crossed, so a single word would be overwritten while MCLK reads it
  smb_write_s wr_slot_r [2];
  smb_write_s wr_slot_nxt [2];
  logic [2:0] addr_l1_r, addr_l2_r, addr_sel_s;
  logic [7:0] byte_v;
  logic start_pend;
  // Toggle is settled well before the first clock rise by the start hold time
  assign start_pend = start_tog_r != start_seen_r;
  always_comb begin
    state_nxt = state_r;
    bitcnt_nxt = bitcnt_r;
    shift_nxt = shift_r;
    ack_nxt = ack_r;
    ptr_nxt = ptr_r;
    remain_nxt = remain_r;
    wr_slot_nxt = wr_slot_r;
    wr_tog_nxt = wr_tog_r;
    start_seen_nxt = start_seen_r;
    byte_v = {shift_r[6:0], SDA_IN};
    if (start_pend) begin
      start_seen_nxt = start_tog_r;
      state_nxt = ST_ADDR;
      bitcnt_nxt = 4'h1;
      shift_nxt = {7'h00, SDA_IN};
      ack_nxt = 1'b0;
    end else if (state_r == ST_IDLE) begin
      bitcnt_nxt = 4'h0;
    end else if (bitcnt_r == `SMB_ACK_SLOT) begin
      bitcnt_nxt = 4'h0;
      ack_nxt = 1'b0;
    end else begin
      shift_nxt = byte_v;
      bitcnt_nxt = bitcnt_r + 4'h1;
      if (bitcnt_r == `SMB_LAST_BIT) begin
        case (state_r)
          ST_ADDR: begin
            // Only a write to our own address is taken
            if (byte_v == {`SMB_ADDR_BASE, addr_l2_r, 1'b0}) begin
              ack_nxt = 1'b1;
              state_nxt = ST_OFFS;
            end else begin
              ack_nxt = 1'b0;
              state_nxt = ST_IGNORE;
            end
          end
          ST_OFFS: begin
            ptr_nxt = byte_v;
            ack_nxt = 1'b1;
            state_nxt = ST_CNT;
          end
          ST_CNT: begin
            // A zero count leaves nothing to write, so data bytes get no ack
            remain_nxt = byte_v;
            ack_nxt = 1'b1;
            state_nxt = ST_DATA;
          end
          ST_DATA: begin
            if (remain_r != 8'h00) begin
              wr_slot_nxt[~wr_tog_r] = '{offset: ptr_r, data: byte_v};
              wr_tog_nxt = ~wr_tog_r;
              ptr_nxt = ptr_r + 8'h01;
              remain_nxt = remain_r - 8'h01;
              ack_nxt = 1'b1;
            end else begin
              ack_nxt = 1'b0;
              state_nxt = ST_IGNORE;
            end
          end
          default: ack_nxt = 1'b0;
        endcase
      end
    end
  end
  always_ff @(posedge SCL or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= ST_IDLE;
      bitcnt_r <= 4'h0;
      shift_r <= 8'h00;
      ack_r <= 1'b0;
      ptr_r <= 8'h00;
      remain_r <= 8'h00;
      wr_slot_r <= '{default: '0};
      wr_tog_r <= 1'b0;
      start_seen_r <= 1'b0;
      addr_l1_r <= 3'h0;
      addr_l2_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      bitcnt_r <= bitcnt_nxt;
      shift_r <= shift_nxt;
      ack_r <= ack_nxt;
      ptr_r <= ptr_nxt;
      remain_r <= remain_nxt;
      wr_slot_r <= wr_slot_nxt;
      wr_tog_r <= wr_tog_nxt;
      start_seen_r <= start_seen_nxt;
      addr_l1_r <= addr_sel_s;
      addr_l2_r <= addr_l1_r;
    end
  end

  // Acknowledge is driven from the falling edge so data is stable around the rise
  logic sda_oe_r, sda_oe_nxt;
  always_comb begin
    sda_oe_nxt = (bitcnt_r == `SMB_ACK_SLOT) && ack_r;
  end
  always_ff @(negedge SCL or negedge RST_N) begin
    if (!RST_N) sda_oe_r <= 1'b0;
    else sda_oe_r <= sda_oe_nxt;
  end
  assign SDA_OE = sda_oe_r;
  assign SDA_OUT = 1'b0;

  // System domain, clocked by MCLK
  strap_s pin_l1_r, pin_l2_r, pin_l1_nxt;
  logic [2:0] wr_sync_r, wr_sync_nxt;
  logic [7:0] ctrl0_r, ctrl0_nxt, ctrl1_r, ctrl1_nxt, wr_cnt_r, wr_cnt_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic [11:0] en_r, en_nxt, oe_bits, oe_pins;
  smb_write_s land_word;
  logic [3:0] misc_r, misc_nxt;
  logic [1:0] rate_r, rate_nxt, sel;
  logic smb_wr, apb_setup, apb_wr;
  assign addr_sel_s = {pin_l2_r.addr2_n_bypass, pin_l2_r.addr_lo};
  assign smb_wr = wr_sync_r[2] ^ wr_sync_r[1];
  // The slot named by the second sync stage was filled an MCLK edge or more ago
  assign land_word = wr_slot_r[wr_sync_r[1]];
  assign sel = reg_sel(PADDR);
  assign apb_setup = PSEL && !PENABLE;
  assign apb_wr = PSEL && PENABLE && PWRITE;
  assign oe_bits = {ctrl1_r[`CTRL1_OE_HI_MSB:`CTRL1_OE_HI_LSB], ctrl0_r};
  assign oe_pins = {pin_l2_r.oe_10_11_n, pin_l2_r.oe_10_11_n, pin_l2_r.oe_n};

  generate
    for (genvar i = 0; i < 12; i++) begin : g_pair
      always_comb begin
        en_nxt[i] = !pin_l2_r.pwr_down && !oe_pins[i] && oe_bits[i];
      end
    end
  endgenerate

  always_comb begin
    pin_l1_nxt = '{pwr_down: POWER_GOOD_POWERDOWN, freq_high: FREQUENCY_RANGE_SELECT,
                   addr2_n_bypass: BUS_ADDRESS_SELECT[2], bw_low: PLL_BANDWIDTH_SELECT,
                   oe_10_11_n: OE_10_11_N, oe_n: OE_N, addr_lo: BUS_ADDRESS_SELECT[1:0]};
    wr_sync_nxt = {wr_sync_r[1:0], wr_tog_r};
    ctrl0_nxt = ctrl0_r;
    ctrl1_nxt = ctrl1_r;
    wr_cnt_nxt = wr_cnt_r;
    prdata_nxt = prdata_r;
    if (apb_wr && sel == 2'h0) ctrl0_nxt = PWDATA[7:0];
    if (apb_wr && sel == 2'h1) ctrl1_nxt = {2'b00, PWDATA[5:0]};
    // An SMBus write landing in the same cycle as an APB write takes precedence
    if (smb_wr) begin
      wr_cnt_nxt = wr_cnt_r + 8'h01;
      if (land_word.offset == `SMB_REG_CTRL0) ctrl0_nxt = land_word.data;
      if (land_word.offset == `SMB_REG_CTRL1) ctrl1_nxt = {2'b00, land_word.data[5:0]};
    end
    if (apb_setup) begin
      case (sel)
        2'h0: prdata_nxt = {24'h000000, ctrl0_r};
        2'h1: prdata_nxt = {24'h000000, ctrl1_r};
        2'h2: prdata_nxt = {16'h0000, wr_cnt_r, misc_r, pin_l2_r.addr2_n_bypass,
                            pin_l2_r.addr_lo, 1'b0};
        default: prdata_nxt = 32'h00000000;
      endcase
    end
    misc_nxt = {pin_l2_r.pwr_down, pin_l2_r.freq_high, !pin_l2_r.addr2_n_bypass,
                !pin_l2_r.bw_low};
    rate_nxt = {ctrl1_r[`CTRL1_RATE11], ctrl1_r[`CTRL1_RATE10]};
  end
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_l1_r <= '0;
      pin_l2_r <= '0;
      wr_sync_r <= 3'h0;
      ctrl0_r <= `CTRL0_RST;
      ctrl1_r <= `CTRL1_RST;
      wr_cnt_r <= 8'h00;
      prdata_r <= 32'h00000000;
      en_r <= 12'h000;
      misc_r <= 4'h0;
      rate_r <= 2'h0;
    end else begin
      pin_l1_r <= pin_l1_nxt;
      pin_l2_r <= pin_l1_r;
      wr_sync_r <= wr_sync_nxt;
      ctrl0_r <= ctrl0_nxt;
      ctrl1_r <= ctrl1_nxt;
      wr_cnt_r <= wr_cnt_nxt;
      prdata_r <= prdata_nxt;
      en_r <= en_nxt;
      misc_r <= misc_nxt;
      rate_r <= rate_nxt;
    end
  end
  assign DIFF_CLOCK_OUT_EN = en_r;
  assign {POWER_DOWN, FREQ_RANGE_HIGH, PLL_BYPASS, PLL_PLL_BANDWIDTH_SELECT} = misc_r;
  assign PAIR_INPUT_RATE = rate_r;
  assign PRDATA = prdata_r;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && (sel == 2'h3 || (PWRITE && sel == 2'h2));

  // Checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  sequence s_smb_land;
    smb_wr && land_word.offset == `SMB_REG_CTRL0;
  endsequence
  a_pair_enable_gate: assert property (
    DIFF_CLOCK_OUT_EN[3] |-> !$past(pin_l2_r.oe_n[3]) && $past(ctrl0_r[3]) &&
    !$past(pin_l2_r.pwr_down))
    else $error("pair 3 enabled without pin and bit");
  a_shared_pin_gate: assert property (
    $past(pin_l2_r.oe_10_11_n) |-> DIFF_CLOCK_OUT_EN[11:10] == 2'b00)
    else $error("pairs 10/11 drive while shared pin high");
  a_bandwidth_follow: assert property (
    $fell(pin_l2_r.bw_low) |=> PLL_PLL_BANDWIDTH_SELECT)
    else $error("bandwidth select low did not give high bandwidth");
  a_bypass_follow: assert property (
    $changed(pin_l2_r.addr2_n_bypass) |=> PLL_BYPASS == !$past(pin_l2_r.addr2_n_bypass))
    else $error("bypass does not follow select");
  a_power_down_off: assert property (
    POWER_DOWN |-> DIFF_CLOCK_OUT_EN == 12'h000)
    else $error("outputs drive in power down");
  a_smb_write_lands: assert property (
    s_smb_land |=> ctrl0_r == $past(land_word.data))
    else $error("SMBus byte not stored at its offset");
  a_rate_default: assert property (
    $rose(RST_N) |-> PAIR_INPUT_RATE == 2'b00)
    else $error("pairs 10/11 not geared by default");
  sequence s_addr_taken;
    state_r == ST_OFFS && bitcnt_r == `SMB_ACK_SLOT;
  endsequence
  a_addr_match: assert property (@(posedge SCL) disable iff (!RST_N)
    s_addr_taken |-> ack_r && shift_r == {`SMB_ADDR_BASE, addr_l2_r, 1'b0})
    else $error("acknowledged a foreign address");
  a_addr_bypass: assert property (@(posedge SCL) disable iff (!RST_N)
    (s_addr_taken and !shift_r[3]) |-> !addr_l2_r[2])
    else $error("address bit 2 low without bypass select");
  a_foreign_ignored: assert property (@(posedge SCL) disable iff (!RST_N)
    state_r == ST_IGNORE |-> !ack_r && $stable(wr_tog_r))
    else $error("ignored transaction acknowledged or written");
  a_ptr_advance: assert property (@(posedge SCL) disable iff (!RST_N)
    $changed(wr_tog_r) |-> ptr_r == wr_slot_r[wr_tog_r].offset + 8'h01 &&
    remain_r == $past(remain_r) - 8'h01)
    else $error("offset or count did not advance");
  a_ack_driven: assert property (@(negedge SCL) disable iff (!RST_N)
    bitcnt_r == `SMB_ACK_SLOT && ack_r |=> SDA_OE ##1 !SDA_OE)
    else $error("acknowledge not driven for exactly one bit");
endmodule : clkbuf_ctrl
`default_nettype wire

// ==== clkbuf_pkg.sv ====
// Types shared by the clock buffer control logic
`default_nettype none
package clkbuf_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_OFFS, ST_CNT, ST_DATA, ST_IGNORE} link_state_e;
  typedef struct packed {
    logic [7:0] offset;
    logic [7:0] data;
  } smb_write_s;
  typedef struct packed {
    logic pwr_down;
    logic freq_high;
    logic addr2_n_bypass;
    logic bw_low;
    logic oe_10_11_n;
    logic [9:0] oe_n;
    logic [1:0] addr_lo;
  } strap_s;
endpackage : clkbuf_pkg
`default_nettype wire

// ==== smbus_host_model.sv ====
// Behavioural SMBus host that issues indexed block writes
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
  output logic scl,
  output logic sda_drv,
  input wire logic sda_wire
);
  // Bus idles released; the clock stands high outside frames
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // Data moves 1 ns after the clock fall, so no data edge can meet a high clock
  task automatic bit_cycle(input logic b, output logic seen);
    #1 sda_drv = b;
    #5 scl = 1'b1;
    #3 seen = sda_wire;
    #3 scl = 1'b0;
  endtask : bit_cycle

  // Start, bytes MSB first with an ack slot each, stop; a missing ack ends the frame early
  task automatic send_frame(input logic [39:0] bytes, input int n, output logic [4:0] acks);
    logic seen;
    acks = 5'h00;
    #6 sda_drv = 1'b0;
    #6 scl = 1'b0;
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        bit_cycle(bytes[32 - 8 * k + i], seen);
      end
      bit_cycle(1'b1, seen);
      acks[k] = !seen;
      if (seen) break;
    end
    #1 sda_drv = 1'b0;
    #5 scl = 1'b1;
    #6 sda_drv = 1'b1;
    #6;
  endtask : send_frame
endmodule : smbus_host_model
`default_nettype wire

// ==== test_clkbuf_ctrl.sv ====
// Self-checking bench for the clock buffer control block
`timescale 1ns/1ps
`default_nettype none
`include "clkbuf_cfg.svh"
module test_clkbuf_ctrl;
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, scl, sda_drv, sda_oe, sda_out;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [9:0] oe_n;
  logic oe1011_n, bw_sel, freq_sel, pgpd, pll_bandwidth_select, bypass, freq_hi, pwr_dn;
  logic [2:0] addr_sel;
  logic [11:0] clk_en;
  logic [1:0] in_rate;
  int miscompares = 0;
  int num_checks = 0;
  // Open-drain wire with pull-up
  wire logic sda;
  assign sda = sda_drv & ~(sda_oe & ~sda_out);

  clkbuf_ctrl u_clkbuf_ctrl (.MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .OE_N(oe_n), .OE_10_11_N(oe1011_n), .PLL_BANDWIDTH_SELECT(bw_sel),
    .BUS_ADDRESS_SELECT(addr_sel), .FREQUENCY_RANGE_SELECT(freq_sel),
    .POWER_GOOD_POWERDOWN(pgpd), .DIFF_CLOCK_OUT_EN(clk_en), .PLL_PLL_BANDWIDTH_SELECT(pll_bandwidth_select),
    .PLL_BYPASS(bypass), .FREQ_RANGE_HIGH(freq_hi), .POWER_DOWN(pwr_dn),
    .PAIR_INPUT_RATE(in_rate));
  smbus_host_model u_smbus_host_model (.scl(scl), .sda_drv(sda_drv), .sda_wire(sda));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic end_sim();
    if (miscompares == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    logic e;
    apb(1'b1, a, v, d, e);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic e;
    apb(1'b0, a, 32'h0, d, e);
    chk(d, exp);
    chk(e, 32'h0);
  endtask : rdc

  // Pin-derived outputs need three edges; six leaves margin for the SMBus write crossing
  task automatic settle();
    repeat (6) @(posedge mclk);
    @(negedge mclk);
  endtask : settle

  initial begin
    #1_000_000;
    miscompares++;
    end_sim();
  end

  initial begin
    logic [31:0] d;
    logic e;
    logic [4:0] ak;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    oe_n = 10'h000;
    oe1011_n = 1'b0;
    bw_sel = 1'b0;
    freq_sel = 1'b0;
    pgpd = 1'b0;
    addr_sel = 3'h0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    rdc(`APB_CTRL0, 32'hff);
    rdc(`APB_CTRL1, 32'h0f);
    chk(in_rate, 32'h0);
    apb(1'b0, 8'h0c, 32'h0, d, e);
    chk(e, 32'h1);
    for (int v = 0; v < 8; v++) begin
      @(posedge mclk);
      addr_sel <= v[2:0];
      bw_sel <= v[0];
      freq_sel <= v[1];
      settle();
      chk(pll_bandwidth_select, !v[0]);
      chk(bypass, !v[2]);
      chk(freq_hi, v[1]);
      rdc(`APB_STATUS, {25'h0, v[1], !v[2], !v[0], v[2:0], 1'b0});
    end
    chk(clk_en, 32'hfff);
    @(posedge mclk);
    pgpd <= 1'b1;
    settle();
    chk(pwr_dn, 32'h1);
    chk(clk_en, 32'h0);
    @(posedge mclk);
    pgpd <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      wr(`APB_CTRL0, c[0] ? 32'hff : 32'h0);
      wr(`APB_CTRL1, c[0] ? 32'h0f : 32'h0);
      @(posedge mclk);
      oe_n <= {10{c[1]}};
      oe1011_n <= c[1];
      settle();
      chk(clk_en, (c == 1) ? 32'hfff : 32'h0);
    end
    wr(`APB_CTRL1, 32'h3b);
    @(posedge mclk);
    oe_n <= 10'h000;
    settle();
    chk(clk_en, 32'h3ff);
    @(posedge mclk);
    oe1011_n <= 1'b0;
    settle();
    chk(clk_en, 32'hbff);
    chk(in_rate, 32'h3);
    @(posedge mclk);
    addr_sel <= 3'h5;
    settle();
    u_smbus_host_model.send_frame({8'hda, 8'h00, 8'h02, 8'h5a, 8'h26}, 5, ak);
    chk(ak, 32'h1f);
    settle();
    rdc(`APB_CTRL0, 32'h5a);
    rdc(`APB_CTRL1, 32'h26);
    chk(clk_en, 32'h65a);
    chk(in_rate, 32'h2);
    for (int s = 0; s < 8; s++) begin
      @(posedge mclk);
      addr_sel <= s[2:0];
      settle();
      u_smbus_host_model.send_frame({8'hd0 + 8'(2 * s), 8'h00, 8'h01, 8'(s + 1), 8'h00}, 4, ak);
      chk(ak, 32'h0f);
      u_smbus_host_model.send_frame({8'hd0 + 8'((2 * s + 2) % 16), 8'h00, 8'h01, 8'hee, 8'h00},
                                    4, ak);
      chk(ak, 32'h00);
      settle();
      rdc(`APB_CTRL0, s + 1);
      chk(bypass, !s[2]);
    end
    rdc(`APB_STATUS, 32'h00000a4e);
    apb(1'b1, `APB_STATUS, 32'h0, d, e);
    chk(e, 32'h1);
    end_sim();
  end
endmodule : test_clkbuf_ctrl
`default_nettype wire
